// ==== include/irwd_consts.svh ====
// Constants for the infrared wake and seven-segment display block
`ifndef IRWD_CONSTS_SVH
`define IRWD_CONSTS_SVH
`define IRWD_CLK_NS 8
`define IRWD_SAMPLE_NS 100000
`define IRWD_SCAN_NS 3276800
`define IRWD_WAIT_STATES 16
`define IRWD_WAIT_MIN 8
`define IRWD_WAIT_MAX 16384
`define IRWD_STAB_CYCLES 32
`define IRWD_BIT_THRESH 8'd17
`define IRWD_LEADER_MIN 8'd40
`define IRWD_GAP_MAX 8'hff
`define IRWD_LAST_BIT 3'd7
`define IRWD_LAST_BYTE 2'd3
`define IRWD_SEG_DASH 8'h02
`define IRWD_SEG_BLANK 8'h00
`define IRWD_FIFO_WIDTH 8
`define IRWD_FIFO_DEPTH 16
`endif

// ==== include/irwd_pkg.sv ====
// Types and segment decode shared by the display block
package irwd_pkg;
  typedef enum logic [1:0] {ST_STANDBY, ST_WAKE, ST_RECEIVE, ST_SHOW} irwd_state_e;
  typedef logic [7:0] irwd_seg_t;

  // Hex nibble to segments a..g,dp on bits 7..0, high lights
  function automatic irwd_seg_t irwd_hex_seg(input logic [3:0] nib);
    irwd_seg_t s;
    s = 8'h00;
    unique case (nib)
      4'h0: s = 8'hfc;
      4'h1: s = 8'h60;
      4'h2: s = 8'hda;
      4'h3: s = 8'hf2;
      4'h4: s = 8'h66;
      4'h5: s = 8'hb6;
      4'h6: s = 8'hbe;
      4'h7: s = 8'he4;
      4'h8: s = 8'hfe;
      4'h9: s = 8'hf6;
      4'ha: s = 8'hee;
      4'hb: s = 8'h3e;
      4'hc: s = 8'h9c;
      4'hd: s = 8'h7a;
      4'he: s = 8'h9e;
      4'hf: s = 8'h8e;
    endcase
    return s;
  endfunction
endpackage

// ==== include/irwd_stream_if.sv ====
// Valid/ready byte stream between receiver, buffer and display
`timescale 1ns/10ps
interface irwd_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data; // Payload
  logic valid; // Source has data
  logic ready; // Sink takes data
  modport source(output data, output valid, input ready);
  modport sink(input data, input valid, output ready);
endinterface

// ==== rtl/irwd_fifo.sv ====
// Synchronous FIFO holding received bytes until the display takes them
`timescale 1ns/10ps
`include "irwd_consts.svh"
module irwd_fifo import irwd_pkg::*; #(
  parameter int WIDTH = `IRWD_FIFO_WIDTH,
  parameter int DEPTH = `IRWD_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  irwd_stream_if.sink in_if,
  irwd_stream_if.source out_if
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap relies on a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("irwd_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH]; // Storage array
  logic [AW-1:0] wr_ptr; // Next write slot
  logic [AW-1:0] rd_ptr; // Next read slot
  logic [AW:0] count; // Words held
  logic do_wr; // Push this cycle
  logic do_rd; // Pop this cycle

  // Honest flags straight from the count, both held low during flush
  assign in_if.ready = (count != (AW+1)'(DEPTH)) && !flush;
  assign out_if.valid = (count != '0) && !flush;
  assign out_if.data = mem[rd_ptr];
  assign do_wr = in_if.valid && in_if.ready;
  assign do_rd = out_if.valid && out_if.ready;

  // Storage write, no reset needed on data
  always_ff @(posedge core_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_if.data;
    end
  end

  // Pointers and count; flush empties in one cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ==== rtl/irwd_top.sv ====
// Infrared wake, frame receiver and two-digit seven-segment display
// Function
// - Wake line low in standby starts wake
// - Wait stabilization plus programmable 8..16384 states
// - Waiting count supports sixteen states
// - Sample infrared input every 0.1 ms
// - Frame is four bytes, all stored
// - Bits enter each byte LSB first
// - Show one byte as two hex digits
// - Swap lit digit every 3.2768 ms
// - Exactly one digit select active, alternating
// - Advance button steps bytes, then dashes
// - Sleep button after display returns to standby
// - Segment outputs are active high
// - Wake interrupt masked until standby again
`timescale 1ns/10ps
`include "irwd_consts.svh"
module irwd_top import irwd_pkg::*; #(
  parameter int SAMPLE_CYCLES = `IRWD_SAMPLE_NS / `IRWD_CLK_NS,
  parameter int SCAN_CYCLES = `IRWD_SCAN_NS / `IRWD_CLK_NS,
  parameter int WAIT_STATES = `IRWD_WAIT_STATES,
  parameter int STAB_CYCLES = `IRWD_STAB_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wake_irq_input,
  input wire logic ir_sample_input,
  input wire logic advance_button_input,
  input wire logic sleep_button_input,
  output logic [7:0] segment_out,
  output logic digit_select_a,
  output logic digit_select_b,
  output logic active_mode
);
  localparam int WAKE_TOTAL = STAB_CYCLES + WAIT_STATES;

  // Refuse settings the counters cannot serve
  if (WAIT_STATES < `IRWD_WAIT_MIN || WAIT_STATES > `IRWD_WAIT_MAX ||
      STAB_CYCLES < 1 || WAKE_TOTAL >= 65536 ||
      SAMPLE_CYCLES < 3 || SAMPLE_CYCLES >= (1 << 20) ||
      SCAN_CYCLES < 2 || SCAN_CYCLES >= (1 << 20)) begin : g_bad_param
    $error("irwd_top: parameter out of range");
  end

  irwd_state_e st; // Operating mode
  logic irq_en; // Wake interrupt enable
  logic [15:0] wait_cnt; // Wake delay counter
  logic [19:0] samp_cnt; // Sample compare timer
  logic [19:0] scan_cnt; // Scan timer
  logic sample_tick; // Sample event
  logic scan_tick; // Scan overflow
  logic rx_run; // Receiver not stalled
  logic ir_prev; // Level at previous sample
  logic ir_fall; // Pulse start seen at sample
  logic [7:0] gap; // Samples since last pulse start
  logic in_frame; // Leader seen
  logic [2:0] bit_cnt; // Bit within byte
  logic [1:0] byte_cnt; // Byte within frame
  logic [7:0] rx_byte; // Assembly shift register
  logic new_bit; // Decoded bit value
  logic bit_ok; // Data bit decoded this sample
  logic push_valid; // Byte waiting for buffer
  logic [7:0] push_data; // Byte to buffer
  logic push_done; // Buffer took byte
  logic first_show; // Load first byte on entry
  logic take; // Display pulls a byte
  logic [7:0] shown; // Byte on display
  logic show_end; // Dash indication
  logic digit; // 0 lights low nibble digit
  logic adv_prev; // Advance button history
  logic sleep_prev; // Sleep button history
  logic adv_edge; // Advance press
  logic sleep_edge; // Sleep press
  logic flush; // Drop buffered bytes
  logic [7:0] next_seg; // Segment pattern to latch

  irwd_stream_if #(.WIDTH(8)) push_if ();
  irwd_stream_if #(.WIDTH(8)) pop_if ();

  // Buffer sits between the bit receiver and the display
  irwd_fifo #(.WIDTH(`IRWD_FIFO_WIDTH), .DEPTH(`IRWD_FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .flush(flush),
    .in_if(push_if.sink),
    .out_if(pop_if.source)
  );

  assign push_if.data = push_data;
  assign push_if.valid = push_valid;
  assign push_done = push_valid && push_if.ready;
  // A full buffer holds the receiver, so no sample is lost unseen
  assign rx_run = (st == ST_RECEIVE) && !push_valid;
  assign sample_tick = rx_run && (samp_cnt == 20'(SAMPLE_CYCLES - 1));
  assign scan_tick = scan_cnt == 20'(SCAN_CYCLES - 1);
  assign ir_fall = sample_tick && ir_prev && !ir_sample_input;
  assign bit_ok = ir_fall && in_frame && (gap < `IRWD_LEADER_MIN);
  assign new_bit = gap > `IRWD_BIT_THRESH;
  assign adv_edge = advance_button_input && !adv_prev;
  assign sleep_edge = sleep_button_input && !sleep_prev;
  assign flush = (st == ST_SHOW) && sleep_edge;
  assign take = (st == ST_SHOW) && (first_show || adv_edge);
  assign pop_if.ready = take;
  assign digit_select_a = !digit;
  assign digit_select_b = digit;
  assign active_mode = st != ST_STANDBY;

  // Mode sequencing: standby, wake delay, receive, display
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st <= ST_STANDBY;
      wait_cnt <= '0;
    end else begin
      unique case (st)
        ST_STANDBY: begin
          wait_cnt <= '0;
          // Receiver line pulls low on incoming light
          if (irq_en && !wake_irq_input) begin
            st <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          wait_cnt <= wait_cnt + 16'd1;
          if (wait_cnt == 16'(WAKE_TOTAL - 1)) begin
            st <= ST_RECEIVE;
          end
        end
        ST_RECEIVE: begin
          if (push_done && byte_cnt == `IRWD_LAST_BYTE) begin
            st <= ST_SHOW;
          end
        end
        ST_SHOW: begin
          if (sleep_edge) begin
            st <= ST_STANDBY;
          end
        end
      endcase
    end
  end

  // Wake interrupt masked once taken, rearmed on return to standby
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_en <= 1'b1;
    end else if (st == ST_STANDBY && irq_en && !wake_irq_input) begin
      irq_en <= 1'b0;
    end else if (flush) begin
      irq_en <= 1'b1;
    end
  end

  // Sample compare timer, runs only while receiving
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      samp_cnt <= '0;
    end else if (!rx_run) begin
      samp_cnt <= (st == ST_RECEIVE) ? samp_cnt : '0;
    end else if (sample_tick) begin
      samp_cnt <= '0;
    end else begin
      samp_cnt <= samp_cnt + 20'd1;
    end
  end

  // Pulse-position decode: count samples between pulse starts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ir_prev <= 1'b1;
      gap <= '0;
      in_frame <= 1'b0;
      bit_cnt <= '0;
      rx_byte <= '0;
    end else if (st != ST_RECEIVE) begin
      ir_prev <= 1'b1;
      gap <= '0;
      in_frame <= 1'b0;
      bit_cnt <= '0;
    end else if (sample_tick) begin
      ir_prev <= ir_sample_input;
      if (ir_fall) begin
        gap <= '0;
        if (gap >= `IRWD_LEADER_MIN) begin
          // Long gap is a leader: restart the frame
          in_frame <= 1'b1;
          bit_cnt <= '0;
        end else if (in_frame) begin
          rx_byte <= {new_bit, rx_byte[7:1]};
          bit_cnt <= bit_cnt + 3'd1;
        end
      end else if (gap != `IRWD_GAP_MAX) begin
        gap <= gap + 8'd1;
      end else begin
        in_frame <= 1'b0; // Line dead too long, drop partial frame
      end
    end
  end

  // Completed byte is offered to the buffer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      push_valid <= 1'b0;
      push_data <= '0;
      byte_cnt <= '0;
    end else begin
      if (bit_ok && bit_cnt == `IRWD_LAST_BIT) begin
        push_valid <= 1'b1;
        push_data <= {new_bit, rx_byte[7:1]};
      end else if (push_done) begin
        push_valid <= 1'b0;
      end
      if (st != ST_RECEIVE) begin
        byte_cnt <= '0;
      end else if (push_done) begin
        byte_cnt <= byte_cnt + 2'd1;
      end
    end
  end

  // Button press edges; switches assumed already debounced
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adv_prev <= 1'b0;
      sleep_prev <= 1'b0;
    end else begin
      adv_prev <= advance_button_input;
      sleep_prev <= sleep_button_input;
    end
  end

  // Byte selection: first byte on entry, next on each advance
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      first_show <= 1'b0;
      shown <= '0;
      show_end <= 1'b0;
    end else begin
      first_show <= (st == ST_RECEIVE) && push_done && byte_cnt == `IRWD_LAST_BYTE;
      if (st != ST_SHOW) begin
        // Stale dashes must not greet the next frame
        show_end <= 1'b0;
      end else if (take) begin
        if (pop_if.valid) begin
          shown <= pop_if.data;
          show_end <= 1'b0;
        end else begin
          show_end <= 1'b1;
        end
      end
    end
  end

  // Scan timer free-runs so the digits never freeze
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scan_cnt <= '0;
      digit <= 1'b0;
    end else if (scan_tick) begin
      scan_cnt <= '0;
      digit <= !digit;
    end else begin
      scan_cnt <= scan_cnt + 20'd1;
    end
  end

  // Pattern for the lit digit; blank outside display mode
  always_comb begin
    next_seg = `IRWD_SEG_BLANK;
    if (st == ST_SHOW && !first_show) begin
      if (show_end) begin
        next_seg = `IRWD_SEG_DASH;
      end else if (digit) begin
        next_seg = irwd_hex_seg(shown[7:4]);
      end else begin
        next_seg = irwd_hex_seg(shown[3:0]);
      end
    end
  end

  // Segment register, high level lights a segment
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      segment_out <= `IRWD_SEG_BLANK;
    end else begin
      segment_out <= next_seg;
    end
  end

  // Helper: cycles spent in the wake delay
  logic [15:0] wake_age;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wake_age <= '0;
    end else begin
      wake_age <= (st == ST_WAKE) ? wake_age + 16'd1 : '0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  wake_accept_a: assert property ((st == ST_STANDBY && irq_en && !wake_irq_input)
    |=> st == ST_WAKE && !irq_en) else $error("wake not accepted");
  wake_delay_a: assert property ((st == ST_RECEIVE && $past(st) == ST_WAKE)
    |-> $past(wake_age) == 16'(WAKE_TOTAL - 1)) else $error("wake delay wrong");
  irq_masked_a: assert property (st != ST_STANDBY |-> !irq_en)
    else $error("wake interrupt not masked");
  sample_space_a: assert property ((sample_tick && !$past(push_valid))
    |=> !sample_tick [*2]) else $error("sample events too close");
  lsb_first_a: assert property (bit_ok && bit_cnt != `IRWD_LAST_BIT
    |=> rx_byte[7] == $past(new_bit)) else $error("bit order wrong");
  four_bytes_a: assert property ((st == ST_SHOW && $past(st) == ST_RECEIVE)
    |-> $past(byte_cnt) == `IRWD_LAST_BYTE && $past(push_done))
    else $error("frame not four bytes");
  one_digit_a: assert property (digit_select_a != digit_select_b)
    else $error("digit selects not exclusive");
  scan_swap_a: assert property (scan_tick |=> digit_select_a != $past(digit_select_a))
    else $error("digit did not swap");
  digit_hold_a: assert property (!scan_tick |=> $stable(digit_select_b))
    else $error("digit swapped between overflows");
  end_dash_a: assert property ((st == ST_SHOW && show_end) |=> segment_out == `IRWD_SEG_DASH
    || $past(sleep_edge)) else $error("end indication missing");
  sleep_back_a: assert property ((st == ST_SHOW && sleep_edge) |=> st == ST_STANDBY && irq_en)
    else $error("sleep not honoured");

  wake_seen_c: cover property (st == ST_STANDBY ##1 st == ST_WAKE);
  frame_done_c: cover property (st == ST_RECEIVE ##1 st == ST_SHOW);
  end_shown_c: cover property (st == ST_SHOW && show_end);
  sleep_back_c: cover property (st == ST_SHOW ##1 st == ST_STANDBY);
endmodule

// ==== tb/irwd_ir_model.sv ====
// Behavioural infrared receiver: wake line and demodulated pulse-position data
`timescale 1ns/10ps
module irwd_ir_model #(
  parameter int SAMPLE_CYCLES = 20
) (
  input wire logic core_clk,
  output logic wake_irq_n,
  output logic ir_data
);
  // Both outputs have a pull-up on the receiver, so idle is high
  initial begin
    wake_irq_n = 1'b1;
    ir_data = 1'b1;
  end

  // First burst of carrier pulls the wake line low for a few cycles
  task automatic wake();
    @(negedge core_clk);
    wake_irq_n = 1'b0;
    repeat (4) @(negedge core_clk);
    wake_irq_n = 1'b1;
  endtask

  // One low pulse of three ticks; ticks is the spacing to the next pulse start
  task automatic pulse(input int ticks);
    ir_data = 1'b0;
    repeat (3 * SAMPLE_CYCLES) @(negedge core_clk);
    ir_data = 1'b1;
    repeat ((ticks - 3) * SAMPLE_CYCLES) @(negedge core_clk);
  endtask

  // Leader, 32 bits LSB first, closing pulse; sender complements bytes 2 and 4
  task automatic send_frame(input logic [7:0] c0, input logic [7:0] c2);
    logic [31:0] bits;
    bits = {~c2, c2, ~c0, c0};
    @(negedge core_clk);
    pulse(50);
    for (int i = 0; i < 32; i++) begin
      pulse(bits[i] ? 22 : 11);
    end
    pulse(4);
  endtask
endmodule

// ==== tb/tb_ir_remote_wake_led_display.sv ====
// Self-checking bench: wake, frame receive, display stepping and sleep
`timescale 1ns/10ps
module tb_ir_remote_wake_led_display;
  localparam int SAMPLE = 20; // Shortened sample tick
  localparam int SCAN = 16; // Shortened scan period
  // Segment patterns for hex digits, a..g,dp on bits 7..0
  localparam logic [7:0] SEG_TAB [16] = '{8'hfc, 8'h60, 8'hda, 8'hf2, 8'h66, 8'hb6,
    8'hbe, 8'he4, 8'hfe, 8'hf6, 8'hee, 8'h3e, 8'h9c, 8'h7a, 8'h9e, 8'h8e};
  logic core_clk; // System clock
  logic rst; // Async reset
  logic wake_irq_input; // From the receiver model
  logic ir_sample_input; // From the receiver model
  logic advance_button_input; // Step button
  logic sleep_button_input; // Standby button
  logic [7:0] segment_out;
  logic digit_select_a;
  logic digit_select_b;
  logic active_mode;
  int n_fail = 0;
  int num_checks = 0;

  irwd_top #(.SAMPLE_CYCLES(SAMPLE), .SCAN_CYCLES(SCAN)) i_dut (
    .core_clk(core_clk),
    .rst(rst),
    .wake_irq_input(wake_irq_input),
    .ir_sample_input(ir_sample_input),
    .advance_button_input(advance_button_input),
    .sleep_button_input(sleep_button_input),
    .segment_out(segment_out),
    .digit_select_a(digit_select_a),
    .digit_select_b(digit_select_b),
    .active_mode(active_mode)
  );

  irwd_ir_model #(.SAMPLE_CYCLES(SAMPLE)) i_ir (
    .core_clk(core_clk),
    .wake_irq_n(wake_irq_input),
    .ir_data(ir_sample_input)
  );

  // Free-running 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Verdict and end of run, shared by the main flow and the watchdog
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait for a fresh lit period of one digit; segments settle a cycle later
  task automatic wait_digit(input logic want_b);
    int n;
    n = 0;
    while (digit_select_b === want_b && n < 4 * SCAN) begin
      @(negedge core_clk);
      n++;
    end
    while (digit_select_b !== want_b && n < 8 * SCAN) begin
      @(negedge core_clk);
      n++;
    end
    repeat (2) @(negedge core_clk);
  endtask

  // Low nibble on the first digit, high nibble on the second
  task automatic show(input logic [7:0] lo, input logic [7:0] hi);
    wait_digit(1'b0);
    chk(segment_out, lo);
    chk({6'h0, digit_select_a, digit_select_b}, 8'h02);
    wait_digit(1'b1);
    chk(segment_out, hi);
    chk({6'h0, digit_select_a, digit_select_b}, 8'h01);
  endtask

  // One button press: high for a cycle, then low
  task automatic press(input bit sleep);
    if (sleep) begin
      sleep_button_input = 1'b1;
    end else begin
      advance_button_input = 1'b1;
    end
    @(negedge core_clk);
    sleep_button_input = 1'b0;
    advance_button_input = 1'b0;
    repeat (3) @(negedge core_clk);
  endtask

  // Reset values, and buttons ignored in standby
  task automatic t_reset_state();
    chk({5'h0, active_mode, digit_select_a, digit_select_b}, 8'h02);
    chk(segment_out, 8'h00);
    press(1'b0);
    press(1'b1);
    chk({7'h0, active_mode}, 8'h00);
    chk(segment_out, 8'h00);
  endtask

  // Wake from standby, receive one frame, first byte shown
  task automatic t_wake_frame(input logic [7:0] c0, input logic [7:0] c2);
    int n;
    n = 0;
    i_ir.wake();
    chk({7'h0, active_mode}, 8'h01);
    repeat (100) @(negedge core_clk);
    i_ir.send_frame(c0, c2);
    while (segment_out === 8'h00 && n < 2000) begin
      @(negedge core_clk);
      n++;
    end
    show(SEG_TAB[c0[3:0]], SEG_TAB[c0[7:4]]);
  endtask

  // Digit swaps every scan period, never both lit
  task automatic t_scan();
    int n;
    n = 0;
    wait_digit(1'b1);
    while (digit_select_b === 1'b1 && n < 4 * SCAN) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'(n), 8'(SCAN - 2));
    chk({7'h0, digit_select_a ^ digit_select_b}, 8'h01);
  endtask

  // Step through the remaining bytes, then the end dashes
  task automatic t_advance(input logic [7:0] c0, input logic [7:0] c2);
    logic [7:0] b [3];
    b = '{~c0, c2, ~c2};
    for (int k = 0; k < 3; k++) begin
      press(1'b0);
      show(SEG_TAB[b[k][3:0]], SEG_TAB[b[k][7:4]]);
    end
    press(1'b0);
    show(8'h02, 8'h02);
    press(1'b0);
    show(8'h02, 8'h02);
  endtask

  // Wake line ignored while active, then sleep back to standby
  task automatic t_sleep();
    i_ir.wake();
    chk({7'h0, active_mode}, 8'h01);
    show(8'h02, 8'h02);
    press(1'b1);
    chk({7'h0, active_mode}, 8'h00);
    chk(segment_out, 8'h00);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    advance_button_input = 1'b0;
    sleep_button_input = 1'b0;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_reset_state();
    t_wake_frame(8'h50, 8'h17);
    t_scan();
    t_advance(8'h50, 8'h17);
    t_sleep();
    t_wake_frame(8'h0f, 8'hc3);
    t_advance(8'h0f, 8'hc3);
    t_sleep();
    report_and_stop();
  end

  // Watchdog sized well above two frames plus display stepping
  initial begin
    #(80000 * 8);
    n_fail++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end
endmodule
